// ===== hdl/ufsa_pkg.sv
// Constants, types and timing figures shared by the user flash serial access block
package ufsa_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int WORDS = 512;
    localparam int SECT_W = 8;
    localparam logic [8:0] SECT0_FIRST = 9'h000;
    localparam logic [8:0] SECT0_LAST = 9'h0FF;
    localparam logic [8:0] SECT1_FIRST = 9'h100;
    localparam logic [8:0] SECT1_LAST = 9'h1FF;
    localparam logic [7:0] SECT_LAST_IDX = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Oscillator and self-timed operation timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int OSC_TICK_CYC = 2;
    localparam int OSC_MHZ = CLK_MHZ / OSC_TICK_CYC;
    localparam int OSC_OUT_DIV = 4;
    localparam int OSC_HALF_TICKS = OSC_OUT_DIV / 2;
    localparam int PROG_TIME_US = 40;
    localparam int ERASE_TIME_US = 500;
    localparam int PROG_TICKS = PROG_TIME_US * OSC_MHZ;
    localparam int ERASE_TICKS = ERASE_TIME_US * OSC_MHZ;
    localparam int TICK_W = 16;
    localparam int FIFO_DEPTH = 2;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic address_shift_select;
        logic address_reg_clock;
        logic addr_serial_in;
        logic data_shift_select;
        logic data_reg_clock;
        logic data_serial_in;
        logic program_req;
        logic erase_req;
    } ufsa_serial_s;

    typedef struct packed {
        logic req;
        logic write;
        logic erase;
        logic [8:0] addr;
        logic [15:0] wdata;
    } ufsa_tap_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_READ = 5'h02,
        ST_PROG = 5'h04,
        ST_ERASE = 5'h08,
        ST_HOLD = 5'h10
    } ufsa_state_e;

endpackage : ufsa_pkg

// ===== hdl/ufsa_core.sv
// User flash serial access block: array, serial shifters, self-timed program and erase
//
// Overview of operation
// - 512 words addressed by a 9-bit address, 000h through 1FFh.
// - Each stored word is 16 bits; narrower widths are left to outside logic.
// - Lower sector is 000h-0FFh, upper sector is 100h-1FFh.
// - Erase clears one sector per operation; two erases clear everything.
// - Erasing or programming one sector leaves the other sector untouched.
// - An internal oscillator times the program and erase sequences.
// - The oscillator divided by four is driven out for user clocking.
// - Divided output runs near 5 MHz, fixed, inside 3.3 to 5.5 MHz.
// - A program or erase request starts the self-timed algorithm.
// - Busy falls only after the internal operation has finished.
// - A test access port also reads and programs the array.
// - Single reads and stream reads of consecutive words are supported.
// - Address clock with shift-select low increments the address.
// - Serial address and data shifters are 9 and 16 bits wide.
// - Inputs accept global clock pins or general routing alike.
`timescale 1ns/1ps
module ufsa_core
    import ufsa_pkg::*;
#(
    parameter int ERASE_TICKS_P = ERASE_TICKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire ufsa_serial_s ser_in,
    input wire ufsa_tap_s tap_in,
    output logic data_serial_out,
    output logic busy,
    output logic divided_osc_output,
    output logic tap_ack,
    output logic [15:0] tap_rdata
);

    // ------------------------------------------------------------
    // Storage and registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [WORDS];
    ufsa_state_e state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] dreg_r, dreg_nxt;
    logic [ADDR_W-1:0] op_addr_r, op_addr_nxt;
    logic [DATA_W-1:0] op_data_r, op_data_nxt;
    logic [TICK_W-1:0] ticks_r, ticks_nxt;
    logic [SECT_W-1:0] ecnt_r, ecnt_nxt;
    logic ewalk_r, ewalk_nxt;
    logic busy_r, busy_nxt;
    logic tap_ack_r, tap_ack_nxt;
    logic [DATA_W-1:0] tap_rdata_r, tap_rdata_nxt;
    logic aclk_prev_r, dclk_prev_r;
    logic sel_prev_r;
    logic [DATA_W-1:0] rd_q_r;
    logic [1:0] osc_div_r, osc_div_nxt;
    logic [1:0] osc_ph_r, osc_ph_nxt;
    logic osc_out_r, osc_out_nxt;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;
    logic [DATA_W-1:0] fifo_mem_r [FIFO_DEPTH];
    logic fifo_wp_r, fifo_rp_r, fifo_wp_nxt, fifo_rp_nxt;
    logic [1:0] fifo_cnt_r, fifo_cnt_nxt;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic aclk_edge, dclk_edge, sel_fall, osc_tick;

    // Plain edge detect; inputs are synchronous so any routing source is fine
    assign aclk_edge = ser_in.address_reg_clock & ~aclk_prev_r;
    assign dclk_edge = ser_in.data_reg_clock & ~dclk_prev_r;
    assign sel_fall = sel_prev_r & ~ser_in.address_shift_select;

    // ------------------------------------------------------------
    // Internal oscillator and divided output
    // ------------------------------------------------------------
    assign osc_tick = (osc_div_r == 2'(OSC_TICK_CYC - 1));

    // Fixed division, so the output rate cannot be changed by the user
    always_comb begin
        osc_div_nxt = osc_tick ? 2'h0 : osc_div_r + 2'h1;
        osc_ph_nxt = osc_ph_r;
        osc_out_nxt = osc_out_r;
        if (osc_tick) begin
            if (osc_ph_r == 2'(OSC_HALF_TICKS - 1)) begin
                osc_ph_nxt = 2'h0;
                osc_out_nxt = ~osc_out_r;
            end else begin
                osc_ph_nxt = osc_ph_r + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            osc_div_r <= 2'h0;
            osc_ph_r <= 2'h0;
            osc_out_r <= 1'b0;
        end else begin
            osc_div_r <= osc_div_nxt;
            osc_ph_r <= osc_ph_nxt;
            osc_out_r <= osc_out_nxt;
        end
    end

    a_osc_period: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(osc_out_r) |=> osc_out_r [*3] ##1 !osc_out_r)
        else $error("divided oscillator high phase not four cycles");

    // ------------------------------------------------------------
    // Two-entry read buffer between array and data shifter
    // ------------------------------------------------------------
    assign fifo_in_ready = (fifo_cnt_r != 2'(FIFO_DEPTH));
    assign fifo_out_valid = (fifo_cnt_r != 2'h0);
    assign fifo_in_valid = state_r == ST_READ;
    // Shifter drains a word only on a load strobe, so a slow reader stalls reads
    assign fifo_out_ready = dclk_edge & ~ser_in.data_shift_select;

    always_comb begin
        fifo_wp_nxt = fifo_wp_r;
        fifo_rp_nxt = fifo_rp_r;
        fifo_cnt_nxt = fifo_cnt_r;
        if (fifo_in_valid && fifo_in_ready) begin
            fifo_wp_nxt = ~fifo_wp_r;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            fifo_rp_nxt = ~fifo_rp_r;
        end
        if ((fifo_in_valid && fifo_in_ready) && !(fifo_out_valid && fifo_out_ready)) begin
            fifo_cnt_nxt = fifo_cnt_r + 2'h1;
        end else if (!(fifo_in_valid && fifo_in_ready) && (fifo_out_valid && fifo_out_ready)) begin
            fifo_cnt_nxt = fifo_cnt_r - 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fifo_wp_r <= 1'b0;
            fifo_rp_r <= 1'b0;
            fifo_cnt_r <= 2'h0;
        end else begin
            fifo_wp_r <= fifo_wp_nxt;
            fifo_rp_r <= fifo_rp_nxt;
            fifo_cnt_r <= fifo_cnt_nxt;
        end
        if (fifo_in_valid && fifo_in_ready) begin
            fifo_mem_r[fifo_wp_r] <= rd_q_r;
        end
    end

    // ------------------------------------------------------------
    // Serial address and data shifters
    // ------------------------------------------------------------
    always_comb begin
        addr_nxt = addr_r;
        dreg_nxt = dreg_r;
        // Address moves only while idle so an operation keeps its target
        if (aclk_edge && state_r == ST_IDLE) begin
            if (ser_in.address_shift_select) begin
                addr_nxt = {addr_r[ADDR_W-2:0], ser_in.addr_serial_in};
            end else begin
                addr_nxt = addr_r + 9'h001;
            end
        end
        if (dclk_edge) begin
            if (ser_in.data_shift_select) begin
                dreg_nxt = {dreg_r[DATA_W-2:0], ser_in.data_serial_in};
            end else if (fifo_out_valid) begin
                dreg_nxt = fifo_mem_r[fifo_rp_r];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_r <= ADDR_RST;
            dreg_r <= DATA_RST;
            aclk_prev_r <= 1'b0;
            dclk_prev_r <= 1'b0;
            sel_prev_r <= 1'b0;
        end else begin
            addr_r <= addr_nxt;
            dreg_r <= dreg_nxt;
            aclk_prev_r <= ser_in.address_reg_clock;
            dclk_prev_r <= ser_in.data_reg_clock;
            sel_prev_r <= ser_in.address_shift_select;
        end
    end

    a_addr_incr: assert property (@(posedge sys_clk) disable iff (reset)
        aclk_edge && !ser_in.address_shift_select && state_r == ST_IDLE
        |=> addr_r == $past(addr_r) + 9'h001)
        else $error("address did not increment by one");
    a_addr_shift: assert property (@(posedge sys_clk) disable iff (reset)
        aclk_edge && ser_in.address_shift_select && state_r == ST_IDLE
        |=> addr_r == {$past(addr_r[7:0]), $past(ser_in.addr_serial_in)})
        else $error("address bit not shifted in");
    a_data_msb: assert property (@(posedge sys_clk) disable iff (reset)
        dclk_edge && ser_in.data_shift_select |=> ##1 data_serial_out == $past(dreg_r[14], 2))
        else $error("serial data not leaving msb first");

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        op_addr_nxt = op_addr_r;
        op_data_nxt = op_data_r;
        ticks_nxt = ticks_r;
        ecnt_nxt = ecnt_r;
        ewalk_nxt = ewalk_r;
        busy_nxt = busy_r;
        tap_ack_nxt = 1'b0;
        tap_rdata_nxt = tap_rdata_r;
        mem_we = 1'b0;
        mem_wa = op_addr_r;
        mem_wd = op_data_r & mem[op_addr_r];
        unique case (state_r)
            ST_IDLE: begin
                // Requests from the test port win over the user port
                if (tap_in.req && (tap_in.write || tap_in.erase)) begin
                    op_addr_nxt = tap_in.addr;
                    op_data_nxt = tap_in.wdata;
                    busy_nxt = 1'b1;
                    ewalk_nxt = tap_in.erase;
                    ecnt_nxt = 8'h00;
                    ticks_nxt = tap_in.erase ? TICK_W'(ERASE_TICKS_P) : TICK_W'(PROG_TICKS);
                    state_nxt = tap_in.erase ? ST_ERASE : ST_PROG;
                end else if (tap_in.req) begin
                    tap_rdata_nxt = mem[tap_in.addr];
                    tap_ack_nxt = 1'b1;
                end else if (ser_in.erase_req) begin
                    op_addr_nxt = addr_r;
                    busy_nxt = 1'b1;
                    ewalk_nxt = 1'b1;
                    ecnt_nxt = 8'h00;
                    ticks_nxt = TICK_W'(ERASE_TICKS_P);
                    state_nxt = ST_ERASE;
                end else if (ser_in.program_req) begin
                    op_addr_nxt = addr_r;
                    op_data_nxt = dreg_r;
                    busy_nxt = 1'b1;
                    ticks_nxt = TICK_W'(PROG_TICKS);
                    state_nxt = ST_PROG;
                end else if (sel_fall || (aclk_edge && !ser_in.address_shift_select)) begin
                    state_nxt = ST_READ;
                end
            end
            ST_READ: begin
                if (fifo_in_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_PROG: begin
                if (osc_tick) begin
                    if (ticks_r == TICK_W'(1)) begin
                        // Flash only clears bits; sector must be erased first
                        mem_we = 1'b1;
                        busy_nxt = 1'b0;
                        state_nxt = ST_HOLD;
                    end
                    ticks_nxt = ticks_r - TICK_W'(1);
                end
            end
            ST_ERASE: begin
                // One word per cycle across the chosen sector only
                if (ewalk_r) begin
                    mem_we = 1'b1;
                    mem_wa = {op_addr_r[ADDR_W-1], ecnt_r};
                    mem_wd = ERASED_WORD;
                    ecnt_nxt = ecnt_r + 8'h01;
                    ewalk_nxt = (ecnt_r != SECT_LAST_IDX);
                end
                if (osc_tick) begin
                    ticks_nxt = ticks_r - TICK_W'(1);
                    if (ticks_r == TICK_W'(1) && !ewalk_r) begin
                        busy_nxt = 1'b0;
                        state_nxt = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // A request still held after busy falls must not restart the job
                if (!ser_in.program_req && !ser_in.erase_req && !tap_in.req) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            op_addr_r <= ADDR_RST;
            op_data_r <= DATA_RST;
            ticks_r <= '0;
            ecnt_r <= 8'h00;
            ewalk_r <= 1'b0;
            busy_r <= 1'b0;
            tap_ack_r <= 1'b0;
            tap_rdata_r <= DATA_RST;
        end else begin
            state_r <= state_nxt;
            op_addr_r <= op_addr_nxt;
            op_data_r <= op_data_nxt;
            ticks_r <= ticks_nxt;
            ecnt_r <= ecnt_nxt;
            ewalk_r <= ewalk_nxt;
            busy_r <= busy_nxt;
            tap_ack_r <= tap_ack_nxt;
            tap_rdata_r <= tap_rdata_nxt;
        end
    end

    // Array write port and registered read port
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        rd_q_r <= mem[addr_nxt];
    end

    a_busy_start: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == ST_IDLE && !tap_in.req && (ser_in.program_req || ser_in.erase_req) |=> busy_r)
        else $error("busy not raised on request");
    a_busy_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (state_r == ST_PROG || state_r == ST_ERASE) && ticks_r > TICK_W'(1) |=> busy_r)
        else $error("busy fell before the operation ended");
    a_sector_keep: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == ST_ERASE && mem_we |-> mem_wa[8] == op_addr_r[8] && mem_wd == ERASED_WORD)
        else $error("erase touched the other sector");
    a_erase_walk: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(ewalk_r) |-> ewalk_r [*8])
        else $error("sector erase walk cut short");
    a_fifo_bound: assert property (@(posedge sys_clk) disable iff (reset)
        (fifo_cnt_r <= 2'(FIFO_DEPTH)) and
        (fifo_in_valid && !fifo_in_ready && !fifo_out_ready |=> fifo_cnt_r == 2'(FIFO_DEPTH)))
        else $error("read buffer over capacity");

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    assign data_serial_out = dreg_r[DATA_W-1];
    assign busy = busy_r;
    assign divided_osc_output = osc_out_r;
    assign tap_ack = tap_ack_r;
    assign tap_rdata = tap_rdata_r;

endmodule : ufsa_core

// ===== sim/ufsa_user_model.sv
// Behavioural model of the user logic driving the serial flash port
`timescale 1ns/1ps
module ufsa_user_model
    import ufsa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic data_serial_out,
    input wire logic busy,
    output ufsa_serial_s ser_out
);
    // ------------------------------------------------------------
    // Strobes: one high sample, then a low sample before the next
    // ------------------------------------------------------------
    initial ser_out = '0;

    // Serial bit is inverted after use so a stale value never looks valid
    task automatic addr_strobe(input logic sel, input logic bit_v);
        @(posedge sys_clk);
        ser_out.address_shift_select <= sel;
        ser_out.address_reg_clock <= 1'b1;
        ser_out.addr_serial_in <= bit_v;
        @(posedge sys_clk);
        ser_out.address_reg_clock <= 1'b0;
        ser_out.addr_serial_in <= ~bit_v;
        @(posedge sys_clk);
    endtask : addr_strobe

    task automatic data_strobe(input logic sel, input logic din);
        @(posedge sys_clk);
        ser_out.data_shift_select <= sel;
        ser_out.data_reg_clock <= 1'b1;
        ser_out.data_serial_in <= din;
        @(posedge sys_clk);
        ser_out.data_reg_clock <= 1'b0;
        @(posedge sys_clk);
    endtask : data_strobe

    // Nine bits MSB first, then a falling select starts the read
    task automatic set_addr(input logic [8:0] a);
        for (int i = 8; i >= 0; i--) begin
            addr_strobe(1'b1, a[i]);
        end
        @(posedge sys_clk);
        ser_out.address_shift_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : set_addr

    task automatic incr();
        addr_strobe(1'b0, 1'b0);
        repeat (3) @(posedge sys_clk);
    endtask : incr

    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            data_strobe(1'b1, w[i]);
        end
    endtask : shift_word

    // Load from the buffer, then collect sixteen bits MSB first
    task automatic read_word(input logic din, output logic [15:0] w);
        data_strobe(1'b0, din);
        for (int i = 15; i >= 0; i--) begin
            @(negedge sys_clk);
            w[i] = data_serial_out;
            data_strobe(1'b1, din);
        end
    endtask : read_word

    // Request is held until busy falls, and only then released
    task automatic run_op(input bit erase, output int hi, output bit started);
        hi = 0;
        started = 0;
        @(posedge sys_clk);
        if (erase) begin
            ser_out.erase_req <= 1'b1;
        end else begin
            ser_out.program_req <= 1'b1;
        end
        for (int n = 0; n < 4 && !started; n++) begin
            @(negedge sys_clk);
            started = (busy === 1'b1);
        end
        while (started && busy === 1'b1 && hi < 50000) begin
            @(negedge sys_clk);
            hi++;
        end
        @(posedge sys_clk);
        ser_out.erase_req <= 1'b0;
        ser_out.program_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : run_op
endmodule : ufsa_user_model

// ===== sim/testbench.sv
// Self-checking testbench for the user flash serial access block
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module testbench
    import ufsa_pkg::*;
;
    // ------------------------------------------------------------
    // Clock, reset and the block under test
    // ------------------------------------------------------------
    localparam int ERASE_T = 300; // Short erase keeps the run brief
    logic sys_clk;
    logic reset;
    ufsa_serial_s ser;
    ufsa_tap_s tap_in;
    logic data_serial_out;
    logic busy;
    logic divided_osc_output;
    logic tap_ack;
    logic [15:0] tap_rdata;
    int err_total = 0;
    int check_count = 0;
    logic [15:0] w;

    ufsa_core #(.ERASE_TICKS_P(ERASE_T)) uut (.sys_clk(sys_clk), .reset(reset), .ser_in(ser), .tap_in(tap_in),
        .data_serial_out(data_serial_out), .busy(busy), .divided_osc_output(divided_osc_output),
        .tap_ack(tap_ack), .tap_rdata(tap_rdata));
    ufsa_user_model partner (.sys_clk(sys_clk), .data_serial_out(data_serial_out), .busy(busy), .ser_out(ser));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Busy window is allowed a couple of cycles of oscillator phase slack
    task automatic do_op(input bit erase, input int ticks);
        int hi;
        bit st;
        partner.run_op(erase, hi, st);
        `CHK(st, 1'b1)
        `CHK(hi >= OSC_TICK_CYC * ticks - 2 && hi <= OSC_TICK_CYC * ticks + 3, 1'b1)
    endtask : do_op

    task automatic erase_sector(input logic [8:0] a);
        partner.set_addr(a);
        partner.read_word(1'b0, w);
        do_op(1'b1, ERASE_T);
    endtask : erase_sector

    task automatic prog_word(input logic [8:0] a, input logic [15:0] d);
        partner.set_addr(a);
        partner.read_word(1'b0, w);
        partner.shift_word(d);
        do_op(1'b0, PROG_TICKS);
    endtask : prog_word

    // Answer comes one cycle after the request and lasts one cycle
    task automatic tap_read(input logic [8:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        tap_in <= '{req: 1'b1, write: 1'b0, erase: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        tap_in <= '0;
        @(negedge sys_clk);
        `CHK(tap_ack, 1'b1)
        `CHK(tap_rdata, exp)
        @(negedge sys_clk);
        `CHK(tap_ack, 1'b0)
    endtask : tap_read

    // Program or sector erase through the test port, held until busy falls
    task automatic tap_op(input bit erase, input logic [8:0] a, input logic [15:0] d, input int ticks);
        int hi;
        hi = 0;
        @(posedge sys_clk);
        tap_in <= '{req: 1'b1, write: !erase, erase: erase, addr: a, wdata: d};
        repeat (3) @(negedge sys_clk);
        `CHK(busy, 1'b1)
        while (busy === 1'b1 && hi < 50000) begin
            @(negedge sys_clk);
            hi++;
        end
        `CHK(hi >= OSC_TICK_CYC * ticks - 4 && hi <= OSC_TICK_CYC * ticks + 3, 1'b1)
        @(posedge sys_clk);
        tap_in <= '0;
        repeat (2) @(posedge sys_clk);
    endtask : tap_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_osc();
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        for (int n = 0; n < 20 && divided_osc_output !== 1'b0; n++) @(negedge sys_clk);
        for (int n = 0; n < 20 && divided_osc_output !== 1'b1; n++) @(negedge sys_clk);
        while (divided_osc_output === 1'b1 && hi < 20) begin
            @(negedge sys_clk);
            hi++;
        end
        while (divided_osc_output === 1'b0 && lo < 20) begin
            @(negedge sys_clk);
            lo++;
        end
        `CHK(hi, OSC_OUT_DIV * OSC_TICK_CYC / 2)
        `CHK(lo, OSC_OUT_DIV * OSC_TICK_CYC / 2)
        `CHK((hi + lo) * 25 >= 182 && (hi + lo) * 25 <= 303, 1'b1)
        $display("oscillator test done");
    endtask : t_osc

    // Both sectors need their own erase before anything is written
    task automatic t_erase();
        erase_sector(SECT0_FIRST);
        erase_sector(SECT1_LAST);
        tap_read(SECT0_FIRST, ERASED_WORD);
        tap_read(SECT0_LAST, ERASED_WORD);
        tap_read(SECT1_FIRST, ERASED_WORD);
        tap_read(SECT1_LAST, ERASED_WORD);
        $display("erase test done");
    endtask : t_erase

    task automatic t_program();
        prog_word(SECT0_LAST, 16'hA5C3);
        prog_word(SECT0_FIRST, 16'h0F0F);
        tap_op(1'b0, SECT1_LAST, 16'h1234, PROG_TICKS);
        partner.set_addr(SECT0_LAST);
        partner.read_word(1'b0, w);
        `CHK(w, 16'hA5C3)
        tap_read(SECT1_LAST, 16'h1234);
        $display("program test done");
    endtask : t_program

    // Third word waits for buffer room; last load finds the buffer empty
    task automatic t_stream();
        partner.set_addr(9'h1FE);
        partner.incr();
        partner.incr();
        partner.read_word(1'b0, w);
        `CHK(w, ERASED_WORD)
        partner.read_word(1'b0, w);
        `CHK(w, 16'h1234)
        partner.read_word(1'b0, w);
        `CHK(w, 16'h0F0F)
        partner.read_word(1'b0, w);
        `CHK(w, 16'h0000)
        $display("stream test done");
    endtask : t_stream

    task automatic t_keep();
        erase_sector(SECT1_FIRST);
        tap_read(SECT0_LAST, 16'hA5C3);
        tap_read(SECT0_FIRST, 16'h0F0F);
        tap_read(SECT1_LAST, ERASED_WORD);
        tap_op(1'b0, SECT1_FIRST, 16'h5A3C, PROG_TICKS);
        tap_op(1'b1, SECT0_LAST, 16'h0000, ERASE_T);
        tap_read(SECT0_FIRST, ERASED_WORD);
        tap_read(SECT1_FIRST, 16'h5A3C);
        $display("sector isolation test done");
    endtask : t_keep

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        tap_in = '0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK({busy, data_serial_out, divided_osc_output, tap_ack}, 4'h0)
        `CHK(tap_rdata, DATA_RST)
        @(posedge sys_clk);
        reset <= 1'b0;
        t_osc();
        t_erase();
        t_program();
        t_stream();
        t_keep();
        end_of_test();
    end

    initial begin
        #(60000 * 25);
        err_total++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : testbench
